/* File: logic/sss_sequencer.sv */
// module: startup sequencer, align then open-loop ramp then closed-loop drive
// Contract
// - dc align runs current pi with align gains only in that phase
// - ac align is part of ramp-up, using drive pi gains
// - torque mode: command is a motor current reference
// - default curve maps command linearly from 0 to maximum current
// - startup begins only when command exceeds the on threshold
// - motor stops only when command drops below the off threshold
// - ramp raises frequency open loop to transition, then closes the loop
// - ramp uses the ramp current reference as current set point
// - ramp steps frequency at step rate for ramp duration
// - ramp frequency trajectory ignores the ramp current reference
// - drive phase clamps the current set point to the drive current limit
// - drive uses drive pi gains and observer angle and frequency gains
// - stages run in order: align, ramp-up, drive
// - dc align holds fixed d current for align duration, then ramps
module sss_sequencer (
   input  wire logic                                 clock,
   input  wire logic                                 rstn,
   input  wire logic [sss_pkg::CMD_W-1:0]            command,
   input  wire logic [sss_pkg::CMD_W-1:0]            command_on_threshold,
   input  wire logic [sss_pkg::CMD_W-1:0]            command_off_threshold,
   input  wire logic [sss_pkg::CUR_W-1:0]            max_system_current,
   input  wire logic                                 ac_align_select,
   input  wire logic [sss_pkg::GAIN_W-1:0]           align_current_prop_gain,
   input  wire logic [sss_pkg::GAIN_W-1:0]           align_current_integ_gain,
   input  wire logic [sss_pkg::GAIN_W-1:0]           drive_current_prop_gain,
   input  wire logic [sss_pkg::GAIN_W-1:0]           drive_current_integ_gain,
   input  wire logic [sss_pkg::CUR_W-1:0]            align_current_reference,
   input  wire logic [sss_pkg::TIME_W-1:0]           align_duration,
   input  wire logic [sss_pkg::CUR_W-1:0]            ramp_current_reference,
   input  wire logic [sss_pkg::FREQ_W-1:0]           ramp_rate_step,
   input  wire logic [sss_pkg::TIME_W-1:0]           ramp_duration,
   input  wire logic [sss_pkg::CUR_W-1:0]            drive_current_limit,
   input  wire logic [sss_pkg::GAIN_W-1:0]           observer_angle_gain,
   input  wire logic [sss_pkg::GAIN_W-1:0]           observer_frequency_gain,
   input  wire logic [sss_pkg::CUR_W-1:0]            measured_current,
   input  wire logic signed [sss_pkg::ANG_W-1:0]     observer_angle_error,
   output logic      [2:0]                           phase_state,
   output logic                                      motor_on,
   output logic                                      control_update,
   output logic      [sss_pkg::CUR_W-1:0]            current_set_point,
   output logic      [sss_pkg::FREQ_W-1:0]           rotor_frequency,
   output logic      [sss_pkg::ANG_W-1:0]            rotor_angle,
   output logic signed [sss_pkg::VOLT_W-1:0]         drive_voltage,
   output logic                                      closed_loop
);
   sss_pkg::sss_state_t               state;
   sss_pkg::sss_state_t               next_state;
   logic [sss_pkg::PRE_W-1:0]         pre;
   logic [sss_pkg::PRE_W-1:0]         next_pre;
   logic [sss_pkg::TIME_W-1:0]        timer;
   logic [sss_pkg::TIME_W-1:0]        next_timer;
   logic [sss_pkg::FREQ_W-1:0]        next_freq;
   logic [sss_pkg::ANG_W-1:0]         next_angle;
   logic [sss_pkg::CUR_W-1:0]         next_set_point;
   logic                              next_motor_on;
   logic [sss_pkg::CUR_W-1:0]         cmd_current;
   logic [sss_pkg::CUR_W-1:0]         drive_ref;
   logic [sss_pkg::CMD_W-1:0]         cmd_s1;
   logic [sss_pkg::CMD_W-1:0]         cmd_s2;
   logic [sss_pkg::CMD_W-1:0]         cmd_s3;
   logic [sss_pkg::CMD_W-1:0]         cmd_ok;
   logic [sss_pkg::CMD_W-1:0]         next_cmd_ok;
   logic [sss_pkg::CUR_W+sss_pkg::CMD_W-1:0] cmd_product;
   logic                              tick;
   logic signed [sss_pkg::ANG_W-1:0]  ang_corr;
   logic signed [sss_pkg::ANG_W-1:0]  frq_corr;

   sss_pi_if pi_bus ();

   sss_pi u_pi (
      .clock (clock),
      .rstn  (rstn),
      .pi    (pi_bus.core)
   );

   // command pin: three-stage capture, accept once stages two and three agree
   always_comb begin
      next_cmd_ok = (cmd_s2 == cmd_s3) ? cmd_s3 : cmd_ok;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cmd_s1 <= '0;
         cmd_s2 <= '0;
         cmd_s3 <= '0;
         cmd_ok <= '0;
      end else begin
         cmd_s1 <= command;
         cmd_s2 <= cmd_s1;
         cmd_s3 <= cmd_s2;
         cmd_ok <= next_cmd_ok;
      end
   end

   // torque mode: command scaled linearly 0 .. max current
   always_comb begin
      cmd_product = max_system_current * cmd_ok;
      cmd_current = cmd_product[sss_pkg::CUR_W+sss_pkg::CMD_W-1:sss_pkg::CMD_W];
      drive_ref   = (cmd_current > drive_current_limit) ? drive_current_limit
                                                        : cmd_current;
   end

   // update strobe prescaler
   always_comb begin
      tick     = (pre == sss_pkg::PRE_LAST);
      next_pre = tick ? '0 : pre + 1'b1;
   end

   // threshold hysteresis, evaluated once per update
   always_comb begin
      next_motor_on = motor_on;
      if (tick) begin
         // between the thresholds nothing changes
         if (!motor_on && cmd_ok > command_on_threshold) begin
            next_motor_on = 1'b1;
         end else if (motor_on && cmd_ok < command_off_threshold) begin
            next_motor_on = 1'b0;
         end
      end
   end

   // observer corrections, one shift per gain
   always_comb begin
      ang_corr = observer_angle_error >>> observer_angle_gain;
      frq_corr = observer_angle_error >>> observer_frequency_gain;
   end

   // sequencer next state, timers, frequency and angle
   always_comb begin
      next_state     = state;
      next_timer     = timer;
      next_freq      = rotor_frequency;
      next_angle     = rotor_angle;
      next_set_point = current_set_point;
      if (tick) begin
         next_angle = rotor_angle + rotor_frequency;
         case (state)
            sss_pkg::SSS_IDLE: begin
               next_freq      = sss_pkg::FREQ_RESET;
               next_set_point = sss_pkg::CUR_RESET;
               next_timer     = sss_pkg::TIME_RESET;
               next_angle     = sss_pkg::ANG_RESET;
               if (next_motor_on) begin
                  // ac align is folded into the ramp stage
                  next_state = ac_align_select ? sss_pkg::SSS_RAMP
                                               : sss_pkg::SSS_ALIGN;
               end
            end
            sss_pkg::SSS_ALIGN: begin
               next_set_point = align_current_reference;
               next_angle     = sss_pkg::ANG_RESET;
               next_timer     = timer + 1'b1;
               if (timer >= align_duration) begin
                  next_state = sss_pkg::SSS_RAMP;
                  next_timer = sss_pkg::TIME_RESET;
               end
            end
            sss_pkg::SSS_RAMP: begin
               next_set_point = ramp_current_reference;
               // frequency depends only on step and duration
               next_freq  = rotor_frequency + ramp_rate_step;
               next_timer = timer + 1'b1;
               if (timer >= ramp_duration) begin
                  next_state = sss_pkg::SSS_DRIVE;
                  next_freq  = rotor_frequency;
               end
            end
            sss_pkg::SSS_DRIVE: begin
               next_set_point = drive_ref;
               // observer corrects angle and frequency separately
               next_angle = rotor_angle + rotor_frequency
                            + sss_pkg::ANG_W'(ang_corr);
               next_freq  = rotor_frequency + sss_pkg::FREQ_W'(frq_corr);
            end
            default: next_state = sss_pkg::SSS_IDLE;
         endcase
         if (!next_motor_on) begin
            next_state = sss_pkg::SSS_IDLE;
         end
      end
   end

   // current pi request: gain set chosen by phase
   always_comb begin
      pi_bus.step  = tick && (state != sss_pkg::SSS_IDLE);
      pi_bus.clear = (state == sss_pkg::SSS_IDLE);
      pi_bus.error = $signed({1'b0, current_set_point})
                     - $signed({1'b0, measured_current});
      if (state == sss_pkg::SSS_ALIGN) begin
         pi_bus.prop_gain  = align_current_prop_gain;
         pi_bus.integ_gain = align_current_integ_gain;
      end else begin
         pi_bus.prop_gain  = drive_current_prop_gain;
         pi_bus.integ_gain = drive_current_integ_gain;
      end
   end

   // register update strobe; the pulse rises on the same edge that registers the update
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pre            <= '0;
         control_update <= 1'b0;
      end else begin
         pre            <= next_pre;
         control_update <= tick;
      end
   end

   // register on/off state
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         motor_on <= 1'b0;
      end else begin
         motor_on <= next_motor_on;
      end
   end

   // register phase, timer, frequency, angle and set point
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state             <= sss_pkg::SSS_IDLE;
         timer             <= sss_pkg::TIME_RESET;
         rotor_frequency   <= sss_pkg::FREQ_RESET;
         rotor_angle       <= sss_pkg::ANG_RESET;
         current_set_point <= sss_pkg::CUR_RESET;
      end else begin
         state             <= next_state;
         timer             <= next_timer;
         rotor_frequency   <= next_freq;
         rotor_angle       <= next_angle;
         current_set_point <= next_set_point;
      end
   end

   assign phase_state   = state;
   assign closed_loop   = (state == sss_pkg::SSS_DRIVE);
   assign drive_voltage = pi_bus.volt;
endmodule

/* File: logic/sss_pkg.sv */
// package: constants and types for the sensorless startup sequencer
package sss_pkg;
   localparam int CMD_W    = 8;   // command width
   localparam int CUR_W    = 12;  // current / reference width
   localparam int GAIN_W   = 4;   // gain is a shift count
   localparam int FREQ_W   = 16;  // frequency accumulator width
   localparam int TIME_W   = 16;  // phase duration count width
   localparam int ANG_W    = 16;  // electrical angle width
   localparam int VOLT_W   = 16;  // pi output width
   // one control update every this many clocks (50 us at 20 MHz)
   localparam int UPDATE_PERIOD_NS = 50000;
   localparam int CLOCK_PERIOD_NS  = 50;
   localparam int UPDATE_CYCLES    = UPDATE_PERIOD_NS / CLOCK_PERIOD_NS;
   localparam int PRE_W            = 10;
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(UPDATE_CYCLES - 1);
   localparam logic [CUR_W-1:0] CUR_RESET  = 12'h000;
   localparam logic [FREQ_W-1:0] FREQ_RESET = 16'h0000;
   localparam logic [TIME_W-1:0] TIME_RESET = 16'h0000;
   localparam logic [ANG_W-1:0] ANG_RESET  = 16'h0000;

   typedef enum logic [2:0] {
      SSS_IDLE  = 3'b000,
      SSS_ALIGN = 3'b001,
      SSS_RAMP  = 3'b010,
      SSS_DRIVE = 3'b011
   } sss_state_t;
endpackage

/* File: logic/sss_pi_if.sv */
// interface: current pi request and answer between sequencer and pi core
interface sss_pi_if;
   logic                                   step;
   logic                                   clear;
   logic signed [sss_pkg::CUR_W:0]         error;
   logic        [sss_pkg::GAIN_W-1:0]      prop_gain;
   logic        [sss_pkg::GAIN_W-1:0]      integ_gain;
   logic signed [sss_pkg::VOLT_W-1:0]      volt;
   modport seq (output step, output clear, output error, output prop_gain,
                output integ_gain, input volt);
   modport core (input step, input clear, input error, input prop_gain,
                 input integ_gain, output volt);
endinterface

/* File: logic/sss_pi.sv */
// module: shift-gain current pi controller with saturating integrator
module sss_pi (
   input wire logic clock,
   input wire logic rstn,
   sss_pi_if.core   pi
);
   localparam int ACC_W = sss_pkg::VOLT_W + 2;
   logic signed [ACC_W-1:0]            integ;
   logic signed [ACC_W-1:0]            next_integ;
   logic signed [ACC_W-1:0]            sum;
   logic signed [sss_pkg::VOLT_W-1:0]  next_volt;
   localparam logic signed [ACC_W-1:0] LIM_HI = ACC_W'(32767);
   localparam logic signed [ACC_W-1:0] LIM_LO = -ACC_W'(32768);

   // integrate on each update, clamp, form output
   always_comb begin
      next_integ = integ;
      next_volt  = pi.volt;
      sum        = '0;
      if (pi.clear) begin
         next_integ = '0;
         next_volt  = '0;
      end else if (pi.step) begin
         next_integ = integ + ((ACC_W'(pi.error) <<< pi.integ_gain) >>> 4);
         if (next_integ > LIM_HI) next_integ = LIM_HI;
         if (next_integ < LIM_LO) next_integ = LIM_LO;
         sum = next_integ + ((ACC_W'(pi.error) <<< pi.prop_gain) >>> 2);
         if (sum > LIM_HI) sum = LIM_HI;
         if (sum < LIM_LO) sum = LIM_LO;
         next_volt = sum[sss_pkg::VOLT_W-1:0];
      end
   end

   // register pi state
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         integ   <= '0;
         pi.volt <= '0;
      end else begin
         integ   <= next_integ;
         pi.volt <= next_volt;
      end
   end
endmodule

/* File: bench/sss_motor_model.sv */
// partner model: motor phase current and observer error seen by the sequencer
module sss_motor_model (
   input  wire logic               clock,
   input  wire logic               rstn,
   input  wire logic signed [15:0] drive_voltage,
   input  wire logic               closed_loop,
   output logic             [11:0] measured_current,
   output logic signed      [15:0] observer_angle_error
);
   timeunit 1ns;
   timeprecision 1ns;
   // current follows positive drive voltage, observer error only when closed
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         measured_current     <= 12'h000;
         observer_angle_error <= 16'sh0000;
      end else begin
         measured_current     <= drive_voltage[15] ? 12'h000 : drive_voltage[14:3];
         observer_angle_error <= closed_loop ? 16'sh0040 : 16'sh0000; // a small lead
      end
   end
endmodule

/* File: bench/sss_sequencer_assertions.sv */
// checker: phase order, set points and ramp stepping at the sequencer ports
module sss_sequencer_checker (
   input wire logic        clock,
   input wire logic        rstn,
   input wire logic        ac_align_select,
   input wire logic [11:0] align_current_reference,
   input wire logic [11:0] ramp_current_reference,
   input wire logic [15:0] ramp_rate_step,
   input wire logic [11:0] drive_current_limit,
   input wire logic [2:0]  phase_state,
   input wire logic        motor_on,
   input wire logic        control_update,
   input wire logic [11:0] current_set_point,
   input wire logic [15:0] rotor_frequency,
   input wire logic        closed_loop
);
   logic [2:0]  prev_state;
   logic [15:0] prev_freq;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // state and frequency as left by the previous update
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         prev_state <= 3'h0;
         prev_freq  <= 16'h0000;
      end else if (control_update) begin
         prev_state <= phase_state;
         prev_freq  <= rotor_frequency;
      end
   end
   sequence s_upd_in(logic [2:0] s);
      control_update && phase_state == s && prev_state == s;
   endsequence
   a_closed_loop_decode: assert property (closed_loop == (phase_state == 3'h3))
      else $error("closed loop flag disagrees with phase");
   a_align_set_point: assert property (s_upd_in(3'h1) |->
      current_set_point == align_current_reference) else $error("align set point wrong");
   a_ramp_set_point: assert property (s_upd_in(3'h2) |->
      current_set_point == ramp_current_reference) else $error("ramp set point wrong");
   a_ramp_freq_step: assert property (s_upd_in(3'h2) |->
      rotor_frequency == 16'(prev_freq + ramp_rate_step)) else $error("ramp step wrong");
   a_drive_limit: assert property (s_upd_in(3'h3) |->
      current_set_point <= drive_current_limit) else $error("drive limit exceeded");
   a_phase_order: assert property (control_update |-> phase_state == prev_state ||
      phase_state == 3'h0 || phase_state == 3'(prev_state + 3'h1) ||
      (prev_state == 3'h0 && phase_state == 3'h2)) else $error("phase order broken");
   a_align_kind: assert property (control_update && prev_state == 3'h0 && phase_state != 3'h0
      |-> phase_state == (ac_align_select ? 3'h2 : 3'h1))
      else $error("wrong align kind");
   a_state_on_update: assert property ($changed(phase_state) |-> control_update)
      else $error("phase moved off the update");
   a_update_spacing: assert property (control_update |=> !control_update [*8])
      else $error("updates too close");
   a_motor_on_idle: assert property (control_update |->
      motor_on == (phase_state != 3'h0)) else $error("motor on disagrees with phase");
endmodule
bind sss_sequencer sss_sequencer_checker u_chk (.clock, .rstn, .ac_align_select,
   .align_current_reference, .ramp_current_reference, .ramp_rate_step, .drive_current_limit,
   .phase_state, .motor_on, .control_update, .current_set_point, .rotor_frequency, .closed_loop);

/* File: bench/sss_sequencer_bench.sv */
// testbench: start, hysteresis, dc and ac startup paths of the sequencer
module sss_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0, rstn = 1'b0, ac_align_select = 1'b0;
   logic [7:0]  command = 8'h00, command_on_threshold = 8'h28, command_off_threshold = 8'h14;
   logic [11:0] max_system_current = 12'h800, align_current_reference = 12'h100;
   logic [11:0] ramp_current_reference = 12'h180, drive_current_limit = 12'hFFF;
   logic [3:0]  align_current_prop_gain = 4'h2, align_current_integ_gain = 4'h3;
   logic [3:0]  drive_current_prop_gain = 4'h4, drive_current_integ_gain = 4'h5;
   logic [3:0]  observer_angle_gain = 4'h4, observer_frequency_gain = 4'h4;
   logic [15:0] align_duration = 16'h0002, ramp_rate_step = 16'h0010;
   logic [15:0] ramp_duration = 16'h0003, rotor_frequency, rotor_angle;
   logic [11:0] measured_current, current_set_point;
   logic signed [15:0] observer_angle_error, drive_voltage;
   logic [2:0]  phase_state;
   logic        motor_on, control_update, closed_loop;
   int          err_total = 0, check_count = 0;
   // 20 MHz clock
   always #25 clock = ~clock;
   sss_sequencer DUT (.clock, .rstn, .command, .command_on_threshold, .command_off_threshold,
      .max_system_current, .ac_align_select, .align_current_prop_gain,
      .align_current_integ_gain, .drive_current_prop_gain, .drive_current_integ_gain,
      .align_current_reference, .align_duration, .ramp_current_reference, .ramp_rate_step,
      .ramp_duration, .drive_current_limit, .observer_angle_gain, .observer_frequency_gain,
      .measured_current, .observer_angle_error, .phase_state, .motor_on, .control_update,
      .current_set_point, .rotor_frequency, .rotor_angle, .drive_voltage, .closed_loop);
   sss_motor_model u_motor (.clock, .rstn, .drive_voltage, .closed_loop, .measured_current,
      .observer_angle_error);
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // waits for n update pulses, each bounded
   task automatic wait_upd(input int n);
      int k;
      repeat (n) begin
         @(negedge clock);
         for (k = 0; k < 1100 && control_update !== 1'b1; k++) @(negedge clock);
         if (k == 1100) begin
            err_total++;
            complete_run();
         end
      end
   endtask
   task automatic wait_state(input logic [2:0] s);
      int k;
      for (k = 0; k < 12000 && phase_state !== s; k++) @(negedge clock);
      if (k == 12000) begin
         err_total++;
         complete_run();
      end
   endtask
   task automatic drive_cmd(input logic [7:0] c);
      @(posedge clock);
      command <= c;
   endtask
   // main sequence
   initial begin
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      drive_cmd(8'h1E);
      wait_upd(3);
      check_val(phase_state, 16'h0000);
      drive_cmd(8'hC8);
      wait_state(3'h1);
      check_val(motor_on, 16'h0001);
      wait_state(3'h2);
      wait_upd(2);
      check_val(current_set_point, 16'h0180);
      check_val(rotor_angle, 16'h0010);
      check_val(drive_voltage > 16'sh0000, 16'h0001);
      wait_state(3'h3);
      check_val(rotor_frequency, 16'h0030);
      check_val(closed_loop, 16'h0001);
      wait_upd(2);
      check_val(current_set_point, 16'h0640);
      @(posedge clock);
      drive_current_limit <= 12'h300;
      wait_upd(2);
      check_val(current_set_point, 16'h0300);
      check_val(rotor_frequency != 16'h0030, 16'h0001);
      drive_cmd(8'h1E);
      wait_upd(2);
      check_val(phase_state, 16'h0003);
      drive_cmd(8'h0A);
      wait_upd(2);
      check_val(phase_state, 16'h0000);
      check_val(motor_on, 16'h0000);
      @(posedge clock);
      ac_align_select <= 1'b1;
      command         <= 8'hC8;
      wait_upd(2);
      check_val(phase_state, 16'h0002);
      check_val(current_set_point, 16'h0180);
      drive_cmd(8'h0A);
      wait_upd(2);
      check_val(phase_state, 16'h0000);
      complete_run();
   end
endmodule
